// file: core/eeprom_defines.svh
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH

// ==================================================
// instruction opcodes
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_READ_ARRAY 8'h03
`define OP_WRITE_ARRAY 8'h02

// ==================================================
// status register layout and reset values
`define ST_PIN_EN_BIT 7
`define ST_BP_HI 4
`define ST_BP_LO 2
`define ST_LATCH_BIT 1
`define ST_BUSY_BIT 0
`define ST_PIN_EN_RST 1'h0
`define ST_BP_RST 3'h0

// ==================================================
// addressing and timing
`define ADDR_BITS 16
`define PAGE_BITS 6
`define SYS_CLK_KHZ 40000
`define WRITE_TIME_US 5000
`define WRITE_CYCLES ((`WRITE_TIME_US * `SYS_CLK_KHZ) / 1000)

`endif

// file: core/eeprom_pkg.sv
package eeprom_pkg;
  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR,
    PH_WDATA,
    PH_RDATA,
    PH_STATUS_OUT,
    PH_STATUS_IN,
    PH_IGNORE
  } phase_t;
  typedef logic [2:0] blockProt_t;
  typedef logic [7:0] opcode_t;
endpackage : eeprom_pkg

// file: core/commit_if.sv
`timescale 1ns/1ps
interface commit_if;
  logic csHigh;
  logic wpLow;
  logic reqArray;
  logic reqStatus;
  logic pinEnable;
  logic busy;
  logic doneToggle;
  logic commitArray;
  logic commitStatus;
  modport engine (
    input csHigh, wpLow, reqArray, reqStatus, pinEnable,
    output busy, doneToggle, commitArray, commitStatus
  );
  modport core (
    output csHigh, wpLow, reqArray, reqStatus, pinEnable,
    input busy, doneToggle, commitArray, commitStatus
  );
endinterface : commit_if

// file: core/write_engine.sv
`timescale 1ns/1ps
`include "eeprom_defines.svh"
module write_engine #(
  parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // link to the command core
  commit_if.engine cmt
);
  import eeprom_pkg::*;

  localparam int CW = $clog2(WRITE_CYCLES + 1);

  if (WRITE_CYCLES < 2) begin : g_chk
    $error("WRITE_CYCLES must be at least 2");
  end

  logic csPrev_q;
  logic wpSeen_q;
  logic isStatus_q;
  logic busy_q;
  logic toggle_q;
  logic commitArray_q;
  logic commitStatus_q;
  logic [CW-1:0] timer_q;
  logic csRise;
  logic wpBlock;
  logic startArray;
  logic startStatus;
  logic finish;

  assign csRise = cmt.csHigh & ~csPrev_q;
  assign wpBlock = cmt.pinEnable & (wpSeen_q | cmt.wpLow);
  assign startArray = csRise & ~busy_q & cmt.reqArray;
  assign startStatus = csRise & ~busy_q & ~cmt.reqArray & cmt.reqStatus & ~wpBlock;
  assign finish = busy_q & (timer_q == CW'(WRITE_CYCLES - 1));

  // ==================================================
  // pin protection seen anywhere inside the frame
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      csPrev_q <= 1'b1;
      wpSeen_q <= 1'b0;
    end else begin
      csPrev_q <= cmt.csHigh;
      if (cmt.csHigh) begin
        wpSeen_q <= 1'b0;
      end else if (cmt.wpLow) begin
        wpSeen_q <= 1'b1;
      end
    end
  end

  // ==================================================
  // self-timed cycle; once started it always runs out
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      timer_q <= '0;
      isStatus_q <= 1'b0;
    end else if (startArray || startStatus) begin
      busy_q <= 1'b1;
      timer_q <= '0;
      isStatus_q <= startStatus;
    end else if (finish) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      timer_q <= timer_q + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      commitArray_q <= 1'b0;
      commitStatus_q <= 1'b0;
      toggle_q <= 1'b0;
    end else begin
      commitArray_q <= finish & ~isStatus_q;
      commitStatus_q <= finish & isStatus_q;
      if (finish) begin
        toggle_q <= ~toggle_q;
      end
    end
  end

  assign cmt.busy = busy_q;
  assign cmt.doneToggle = toggle_q;
  assign cmt.commitArray = commitArray_q;
  assign cmt.commitStatus = commitStatus_q;

  // ==================================================
  // checks
  sequence arrayStart;
    csRise && !busy_q && cmt.reqArray;
  endsequence

  sequence arrayEnd;
    busy_q && timer_q == CW'(WRITE_CYCLES - 1) && !isStatus_q;
  endsequence

  start_busy_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    arrayStart |=> busy_q [*8])
    else $error("write cycle did not start or ended early");

  busy_cause_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(busy_q) |-> $past(csRise))
    else $error("write cycle started without a deselect");

  wp_abort_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (csRise && !busy_q && !cmt.reqArray && cmt.reqStatus && wpBlock) |=> !busy_q)
    else $error("protected status write was started");

  wp_late_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (busy_q && isStatus_q && cmt.wpLow && !finish) |=> busy_q)
    else $error("status write cycle cut short by protect pin");

  array_commit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    arrayEnd |=> (cmt.commitArray && !busy_q) ##1 !cmt.commitArray)
    else $error("array commit not a single pulse at cycle end");

  done_toggle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cmt.commitArray || cmt.commitStatus) |-> toggle_q != $past(toggle_q))
    else $error("completion not signalled to the latch");
endmodule : write_engine

// file: core/spi_eeprom_command_protect.sv
`timescale 1ns/1ps
`include "eeprom_defines.svh"
// ==================================================
// Overview of operation
// - first eight selected bits form the instruction
// - enable, disable, status read and write opcodes
// - opcode 03h reads array after address
// - opcode 02h writes array with address, data
// - input bits sampled on rising serial clock
// - read data changes on falling serial clock
// - deselected means output off and standby
// - write cycle starts only at deselect after sequence
// - pin protection blocks every status write
// - protect pin falling mid-frame aborts status write
// - started status write completes despite protect pin
// - protect pin ignored when enable bit clear
// - protected blocks never; others need the latch
// - paused: output off, input ignored, state frozen
// - status bit layout: enable, protect, latch, busy
// - busy reads one during write, read only
// - latch set, cleared by command or completion
// - sixteen bit address follows, upper bits ignored
// - page write wraps six low address bits
module spi_eeprom_command_protect #(
  parameter int ADDR_W = 13,
  parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // serial link
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic pause_n,
  input wire logic write_protect_n,
  output logic serial_out,
  output logic serialOutEn
);
  import eeprom_pkg::*;

  localparam int PB = `PAGE_BITS;
  localparam int PAGE = 1 << PB;

  if (ADDR_W < PB + 2 || ADDR_W > `ADDR_BITS) begin : g_chk
    $error("ADDR_W out of range");
  end

  // ==================================================
  // declarations
  commit_if cmt ();

  logic linkRst_n;
  phase_t phase_q;
  phase_t opPhase;
  logic [2:0] bitCnt_q;
  logic [7:0] shiftIn_q;
  opcode_t rxNext;
  logic byteDone;
  logic opDone;
  logic addrByte_q;
  logic isWrite_q;
  logic [`ADDR_BITS-1:0] addr_q;
  logic latch_q;
  logic busyMeta_q;
  logic busyLink_q;
  logic doneMeta_q;
  logic doneLink_q;
  logic doneSeen_q;
  logic reqArray_q;
  logic reqStatus_q;
  logic [7:0] statusNew_q;
  logic [7:0] pageBuf_q [PAGE];
  logic [PAGE-1:0] pageMask_q;
  logic serialOut_q;
  logic readOe_q;
  logic [7:0] statusByte;
  logic [7:0] outByte;
  logic csMeta_q;
  logic csSys_q;
  logic wpMeta_q;
  logic wpSys_q;
  logic pinEn_q;
  blockProt_t bp_q;
  logic [7:0] mem_q [1 << ADDR_W];

  // ==================================================
  // helpers
  function automatic phase_t decodeOp(input opcode_t op, input logic busy);
    if (busy && op != `OP_READ_STATUS) begin
      decodeOp = PH_IGNORE;
    end else begin
      case (op)
        `OP_READ_STATUS: decodeOp = PH_STATUS_OUT;
        `OP_WRITE_STATUS: decodeOp = PH_STATUS_IN;
        `OP_READ_ARRAY: decodeOp = PH_ADDR;
        `OP_WRITE_ARRAY: decodeOp = PH_ADDR;
        default: decodeOp = PH_IGNORE;
      endcase
    end
  endfunction : decodeOp

  // protected ranges are page aligned, so the base page decides
  function automatic logic isProtected(input blockProt_t bp,
                                       input logic [ADDR_W-1:0] a);
    case (bp)
      3'h0: isProtected = 1'b0;
      3'h1, 3'h2, 3'h3, 3'h4: isProtected = (a[ADDR_W-1 -: 2] == 2'(bp - 3'h1));
      3'h5: isProtected = ~a[ADDR_W-1];
      3'h6: isProtected = (a[ADDR_W-1:PB] == '0);
      default: isProtected = &a[ADDR_W-1:PB];
    endcase
  endfunction : isProtected

  // ==================================================
  // link domain: frame state, cleared by deselect
  assign linkRst_n = nrst & ~chip_select_n;
  assign rxNext = {shiftIn_q[6:0], serial_in};
  assign byteDone = pause_n & (bitCnt_q == 3'h7);
  assign opDone = byteDone & (phase_q == PH_OPCODE);
  assign opPhase = decodeOp(rxNext, busyLink_q);

  always_ff @(posedge serial_clock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      phase_q <= PH_OPCODE;
      bitCnt_q <= '0;
      shiftIn_q <= '0;
      addrByte_q <= 1'b0;
      isWrite_q <= 1'b0;
    end else if (pause_n) begin
      shiftIn_q <= rxNext;
      bitCnt_q <= bitCnt_q + 3'h1;
      if (bitCnt_q == 3'h7) begin
        case (phase_q)
          PH_OPCODE: begin
            phase_q <= opPhase;
            isWrite_q <= (rxNext == `OP_WRITE_ARRAY);
          end
          PH_ADDR: begin
            addrByte_q <= ~addrByte_q;
            if (addrByte_q) begin
              phase_q <= isWrite_q ? PH_WDATA : PH_RDATA;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==================================================
  // link domain: address pointer, kept across frames
  always_ff @(posedge serial_clock or negedge nrst) begin
    if (!nrst) begin
      addr_q <= '0;
    end else if (byteDone && phase_q == PH_ADDR) begin
      addr_q <= {addr_q[7:0], rxNext};
    end else if (byteDone && phase_q == PH_RDATA) begin
      addr_q <= addr_q + `ADDR_BITS'(1);
    end else if (byteDone && phase_q == PH_WDATA) begin
      addr_q[PB-1:0] <= addr_q[PB-1:0] + PB'(1);
    end
  end

  // ==================================================
  // link domain: page buffer handed to the write engine
  always_ff @(posedge serial_clock or negedge nrst) begin
    if (!nrst) begin
      pageMask_q <= '0;
    end else if (opDone && opPhase == PH_ADDR && rxNext == `OP_WRITE_ARRAY) begin
      pageMask_q <= '0;
    end else if (byteDone && phase_q == PH_WDATA) begin
      pageMask_q[addr_q[PB-1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge serial_clock) begin
    if (byteDone && phase_q == PH_WDATA) begin
      pageBuf_q[addr_q[PB-1:0]] <= rxNext;
    end
  end

  // ==================================================
  // link domain: requests, true only on a byte boundary
  // they freeze once the clock stops, so the engine reads them after deselect
  always_ff @(posedge serial_clock or negedge nrst) begin
    if (!nrst) begin
      reqArray_q <= 1'b0;
      reqStatus_q <= 1'b0;
      statusNew_q <= '0;
    end else if (pause_n) begin
      if (phase_q == PH_OPCODE) begin
        reqArray_q <= 1'b0;
        reqStatus_q <= 1'b0;
      end else if (phase_q == PH_WDATA) begin
        reqArray_q <= byteDone & latch_q & ~isProtected(bp_q, addr_q[ADDR_W-1:0]);
      end else if (phase_q == PH_STATUS_IN) begin
        reqStatus_q <= byteDone & latch_q;
        if (byteDone) begin
          statusNew_q <= rxNext;
        end
      end
    end
  end

  // ==================================================
  // link domain: engine state brought over
  always_ff @(posedge serial_clock or negedge nrst) begin
    if (!nrst) begin
      busyMeta_q <= 1'b0;
      busyLink_q <= 1'b0;
      doneMeta_q <= 1'b0;
      doneLink_q <= 1'b0;
    end else begin
      busyMeta_q <= cmt.busy;
      busyLink_q <= busyMeta_q;
      doneMeta_q <= cmt.doneToggle;
      doneLink_q <= doneMeta_q;
    end
  end

  // ==================================================
  // link domain: write latch
  always_ff @(posedge serial_clock or negedge nrst) begin
    if (!nrst) begin
      latch_q <= 1'b0;
      doneSeen_q <= 1'b0;
    end else begin
      doneSeen_q <= doneLink_q;
      // set wins: an enable landing as a cycle ends must stick
      if (opDone && !busyLink_q && rxNext == `OP_WRITE_ENABLE) begin
        latch_q <= 1'b1;
      end else if (doneLink_q != doneSeen_q) begin
        latch_q <= 1'b0;
      end else if (opDone && !busyLink_q && rxNext == `OP_WRITE_DISABLE) begin
        latch_q <= 1'b0;
      end
    end
  end

  // ==================================================
  // link domain: output on the falling edge
  // read data comes from the array, status otherwise; quiet outside array and status reads
  always_comb begin
    statusByte = '0;
    statusByte[`ST_PIN_EN_BIT] = pinEn_q;
    statusByte[`ST_BP_HI:`ST_BP_LO] = bp_q;
    statusByte[`ST_LATCH_BIT] = latch_q;
    statusByte[`ST_BUSY_BIT] = busyLink_q;
  end

  assign outByte = (phase_q == PH_RDATA) ? mem_q[addr_q[ADDR_W-1:0]] : statusByte;

  always_ff @(negedge serial_clock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      serialOut_q <= 1'b0;
      readOe_q <= 1'b0;
    end else if (pause_n) begin
      readOe_q <= (phase_q == PH_RDATA) || (phase_q == PH_STATUS_OUT);
      serialOut_q <= outByte[3'h7 - bitCnt_q];
    end
  end

  assign serial_out = serialOut_q;
  // pause must float the pin at once, with no clock edge to do it
  assign serialOutEn = readOe_q & pause_n;

  // ==================================================
  // system domain: pin synchronisers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      csMeta_q <= 1'b1;
      csSys_q <= 1'b1;
      wpMeta_q <= 1'b1;
      wpSys_q <= 1'b1;
    end else begin
      csMeta_q <= chip_select_n;
      csSys_q <= csMeta_q;
      wpMeta_q <= write_protect_n;
      wpSys_q <= wpMeta_q;
    end
  end

  assign cmt.csHigh = csSys_q;
  assign cmt.wpLow = ~wpSys_q;
  assign cmt.reqArray = reqArray_q;
  assign cmt.reqStatus = reqStatus_q;
  assign cmt.pinEnable = pinEn_q;

  write_engine #(
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_engine (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .cmt(cmt)
  );

  // ==================================================
  // system domain: status and array storage
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pinEn_q <= `ST_PIN_EN_RST;
      bp_q <= `ST_BP_RST;
    end else if (cmt.commitStatus) begin
      pinEn_q <= statusNew_q[`ST_PIN_EN_BIT];
      bp_q <= statusNew_q[`ST_BP_HI:`ST_BP_LO];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (cmt.commitArray) begin
      for (int i = 0; i < PAGE; i++) begin
        if (pageMask_q[i]) begin
          mem_q[{addr_q[ADDR_W-1:PB], PB'(i)}] <= pageBuf_q[i];
        end
      end
    end
  end

  // ==================================================
  // checks
  op_status_a: assert property (@(posedge serial_clock) disable iff (!linkRst_n)
    (opDone && rxNext == `OP_READ_STATUS) |=> phase_q == PH_STATUS_OUT)
    else $error("status read not decoded");

  busy_ignore_a: assert property (@(posedge serial_clock) disable iff (!linkRst_n)
    (opDone && busyLink_q && rxNext != `OP_READ_STATUS) |=> phase_q == PH_IGNORE)
    else $error("command obeyed while busy");

  latch_set_a: assert property (@(posedge serial_clock) disable iff (!nrst)
    (opDone && !busyLink_q && rxNext == `OP_WRITE_ENABLE && doneLink_q == doneSeen_q)
    |=> latch_q)
    else $error("enable command did not set the latch");

  pause_hold_a: assert property (@(posedge serial_clock) disable iff (!linkRst_n)
    !pause_n |=> $stable(bitCnt_q) && $stable(shiftIn_q) && $stable(phase_q))
    else $error("sequence advanced while paused");

  page_wrap_a: assert property (@(posedge serial_clock) disable iff (!nrst)
    (byteDone && phase_q == PH_WDATA) |=>
    addr_q[PB-1:0] == $past(addr_q[PB-1:0]) + PB'(1) &&
    addr_q[`ADDR_BITS-1:PB] == $past(addr_q[`ADDR_BITS-1:PB]))
    else $error("page address did not wrap in place");

  read_incr_a: assert property (@(posedge serial_clock) disable iff (!nrst)
    (byteDone && phase_q == PH_RDATA) |=> addr_q == $past(addr_q) + `ADDR_BITS'(1))
    else $error("read pointer did not advance");

  req_protect_a: assert property (@(posedge serial_clock) disable iff (!nrst)
    (byteDone && phase_q == PH_WDATA &&
     (!latch_q || isProtected(bp_q, addr_q[ADDR_W-1:0]))) |=> !reqArray_q)
    else $error("write requested without latch or into protected block");

  cs_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    chip_select_n |-> !serialOutEn)
    else $error("output driven while deselected");
endmodule : spi_eeprom_command_protect

// file: bench/spi_host_model.sv
`timescale 1ns/1ps
// ==================================================
// host side: spi master, clock stands still between frames
module spi_host_model (
  // link pins
  output logic serial_clock,
  output logic chip_select_n,
  output logic serial_in,
  output logic pause_n,
  // device answer
  input wire logic serial_out,
  input wire logic serialOutEn
);
  logic cpol;
  int pauseBit;
  logic pausedEn;

  initial begin
    cpol = 1'b0;
    pauseBit = -1;
    pausedEn = 1'b0;
    serial_clock = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b1;
    pause_n = 1'b1;
  end

  // released pin reads x so an undriven bit never passes
  task automatic frame(input logic [63:0] tx, input int nb, output logic [7:0] rx);
    serial_clock = cpol;
    #80;
    chip_select_n = 1'b0;
    #80;
    for (int i = 0; i < nb * 8; i++) begin
      serial_clock = 1'b0;
      if (i == pauseBit) begin
        // pause after the falling edge, never on it, or that shift is lost
        #40;
        pause_n = 1'b0;
        #60;
        pausedEn = serialOutEn;
        // wiggle data and clock while paused
        repeat (2) begin
          serial_in = ~serial_in;
          #80;
          serial_clock = 1'b1;
          #80;
          serial_clock = 1'b0;
        end
        pause_n = 1'b1;
        #80;
      end
      serial_in = tx[63-i];
      #80;
      serial_clock = 1'b1;
      rx = {rx[6:0], serialOutEn ? serial_out : 1'bx};
      #80;
    end
    serial_clock = cpol;
    chip_select_n = 1'b1;
    serial_in = ~serial_in;
    #400;
  endtask : frame
endmodule : spi_host_model

// file: bench/spi_eeprom_command_protect_bench.sv
`timescale 1ns/1ps
`include "eeprom_defines.svh"
module spi_eeprom_command_protect_bench;
  logic sysClk;
  logic nrst;
  logic wpN;
  logic sck;
  logic csN;
  logic sdi;
  logic pauseN;
  logic sdo;
  logic sdoEn;
  logic [7:0] rx;
  int errCount;
  int checksDone;
  int cycles;

  // ==================================================
  // clock, reset, instances
  initial begin
    sysClk = 1'b0;
    forever #12.5 sysClk = ~sysClk;
  end

  spi_eeprom_command_protect #(.ADDR_W(13), .WRITE_CYCLES(200)) i_spi_eeprom_command_protect (
    .sys_clk(sysClk), .nrst(nrst), .serial_clock(sck), .chip_select_n(csN),
    .serial_in(sdi), .pause_n(pauseN), .write_protect_n(wpN),
    .serial_out(sdo), .serialOutEn(sdoEn));

  spi_host_model i_spi_host_model (
    .serial_clock(sck), .chip_select_n(csN), .serial_in(sdi), .pause_n(pauseN),
    .serial_out(sdo), .serialOutEn(sdoEn));

  // ==================================================
  // access tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic cmd(input logic [7:0] op);
    i_spi_host_model.frame({op, 56'h0}, 1, rx);
  endtask : cmd

  task automatic rdStat(output logic [7:0] s);
    i_spi_host_model.frame({`OP_READ_STATUS, 56'h0}, 2, s);
  endtask : rdStat

  task automatic wrStat(input logic [7:0] v);
    i_spi_host_model.frame({`OP_WRITE_STATUS, v, 48'h0}, 2, rx);
  endtask : wrStat

  task automatic wrArr(input logic [15:0] a, input logic [7:0] d);
    i_spi_host_model.frame({`OP_WRITE_ARRAY, a, d, 32'h0}, 4, rx);
  endtask : wrArr

  task automatic rdArr(input logic [15:0] a, output logic [7:0] d);
    i_spi_host_model.frame({`OP_READ_ARRAY, a, 40'h0}, 4, d);
  endtask : rdArr

  // polls busy; bounded so a stuck engine cannot hang the run
  task automatic waitReady;
    logic [7:0] s;
    int n;
    n = 0;
    s = 8'h01;
    while (s[0] !== 1'b0 && n < 20) begin
      rdStat(s);
      n++;
    end
    if (s[0] !== 1'b0) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, s, 8'h00);
    end
  endtask : waitReady

  task automatic setWp(input logic v);
    @(posedge sysClk);
    #2 wpN = v;
  endtask : setWp

  task automatic testDone;
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : testDone

  // ==================================================
  // timeout
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 40000) begin
      errCount++;
      testDone();
    end
  end

  // ==================================================
  // tests
  initial begin
    errCount = 0;
    checksDone = 0;
    cycles = 0;
    nrst = 1'b0;
    wpN = 1'b1;
    repeat (10) @(posedge sysClk);
    #2 nrst = 1'b1;
    repeat (4) @(posedge sysClk);
    rdStat(rx); check(rx, 8'h00);
    $display("test reset done");
    cmd(`OP_WRITE_ENABLE);
    rdStat(rx); check(rx, 8'h02);
    check({7'h0, sdoEn}, 8'h00);
    cmd(`OP_WRITE_DISABLE);
    rdStat(rx); check(rx, 8'h00);
    $display("test latch done");
    cmd(`OP_WRITE_ENABLE);
    wrArr(16'h0010, 8'h5a);
    rdStat(rx); check(rx, 8'h03);
    waitReady();
    rdArr(16'h0010, rx); check(rx, 8'h5a);
    rdArr(16'he010, rx); check(rx, 8'h5a);
    rdStat(rx); check(rx, 8'h00);
    wrArr(16'h0010, 8'hc3);
    waitReady();
    rdArr(16'h0010, rx); check(rx, 8'h5a);
    $display("test array done");
    cmd(`OP_WRITE_ENABLE);
    i_spi_host_model.frame({`OP_WRITE_ARRAY, 16'h003e, 24'h112233, 16'h0}, 6, rx);
    waitReady();
    rdArr(16'h003e, rx); check(rx, 8'h11);
    rdArr(16'h0000, rx); check(rx, 8'h33);
    $display("test page done");
    cmd(`OP_WRITE_ENABLE);
    wrStat(8'h18);
    waitReady();
    rdStat(rx); check(rx, 8'h18);
    cmd(`OP_WRITE_ENABLE);
    wrArr(16'h0000, 8'h77);
    waitReady();
    rdArr(16'h0000, rx); check(rx, 8'h33);
    rdStat(rx); check(rx, 8'h1a);
    $display("test block done");
    wrStat(8'h80);
    waitReady();
    rdStat(rx); check(rx, 8'h80);
    setWp(1'b0);
    cmd(`OP_WRITE_ENABLE);
    wrStat(8'h1c);
    waitReady();
    rdStat(rx); check(rx, 8'h82);
    setWp(1'b1);
    fork
      wrStat(8'h1c);
      begin
        // pin low only mid-frame, high again before deselect
        #1000;
        setWp(1'b0);
        #500;
        setWp(1'b1);
      end
    join
    setWp(1'b1);
    waitReady();
    rdStat(rx); check(rx, 8'h82);
    wrStat(8'h00);
    waitReady();
    rdStat(rx); check(rx, 8'h00);
    setWp(1'b0);
    cmd(`OP_WRITE_ENABLE);
    wrStat(8'h0c);
    waitReady();
    rdStat(rx); check(rx, 8'h0c);
    setWp(1'b1);
    cmd(`OP_WRITE_ENABLE);
    wrArr(16'h1000, 8'h9e);
    waitReady();
    rdStat(rx); check(rx, 8'h0e);
    wrArr(16'h0fff, 8'h9e);
    waitReady();
    rdArr(16'h0fff, rx); check(rx, 8'h9e);
    $display("test protect pin done");
    i_spi_host_model.pauseBit = 3;
    rdStat(rx); check(rx, 8'h0c);
    check({7'h0, i_spi_host_model.pausedEn}, 8'h00);
    i_spi_host_model.pauseBit = 12;
    rdStat(rx); check(rx, 8'h0c);
    check({7'h0, i_spi_host_model.pausedEn}, 8'h00);
    i_spi_host_model.pauseBit = -1;
    i_spi_host_model.cpol = 1'b1;
    rdStat(rx); check(rx, 8'h0c);
    rdArr(16'h003e, rx); check(rx, 8'h11);
    i_spi_host_model.cpol = 1'b0;
    $display("test pause and mode done");
    testDone();
  end
endmodule : spi_eeprom_command_protect_bench
